// [verilog/pll_pkg.sv]
// constants and types for the clock synthesis block
// assumes one 125 MHz pclk and an apb master
package pll_pkg;
   // ==========================================
   // bus and register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] DIV_OFS = 8'h04;
   localparam logic [7:0] POST_OFS = 8'h08;
   localparam logic [7:0] PHASE_OFS = 8'h0C;
   localparam logic [7:0] DUTY_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] FREQ_OFS = 8'h18;
   localparam int RUN_BIT = 0;
   localparam int CLEAR_BIT = 1;
   localparam int DETEN_BIT = 2;
   localparam int LOCK_BIT = 0;
   localparam int UP_BIT = 1;
   localparam int DN_BIT = 2;
   localparam int FB_POS = 8;
   localparam int B_POS = 8;
   localparam int E_POS = 16;
   localparam logic [2:0] CTRL_RST = 3'h4;
   // ==========================================
   // dividers and phase
   localparam logic [5:0] DIV_MIN = 6'h01;
   localparam logic [5:0] DIV_MAX = 6'h20;
   localparam logic [7:0] PHASE_RST = 8'h00;
   localparam logic [2:0] DUTY_RST = 3'h4;
   localparam int STEPS_PER_OSC = 8;
   localparam int PHASE_STEP_PS = 125;
   localparam logic [7:0] GLOB_COMP = 8'h01;
   localparam logic [7:0] OFF_COMP = 8'h02;
   localparam int MAX_LOOPS = 2;
   // ==========================================
   // loop and lock detector
   localparam int FW_W = 24;
   localparam logic [23:0] FW_RST = 24'h100000;
   localparam logic [23:0] FW_MIN = 24'h000100;
   localparam logic [23:0] FW_MAX = 24'h7F0000;
   localparam logic [23:0] KP = 24'h000400;
   localparam logic [23:0] KI = 24'h000001;
   localparam logic [7:0] LOCK_WIN = 8'h02;
   localparam logic [7:0] LOCK_CNT = 8'h10;
   typedef struct packed {
      logic [5:0] div;
      logic [7:0] phase;
      logic [2:0] duty;
   } post_cfg_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ACQ = 3'b010,
      ST_LOCK = 3'b100
   } lock_state_e;
endpackage : pll_pkg

// [verilog/pll_post_div.sv]
// one post-scale divider with phase offset and duty
// assumes tick marks one eighth of an oscillator period
`timescale 1ns/1ps
module pll_post_div import pll_pkg::*; #(
   parameter logic [7:0] COMP = 8'h00
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hold,
   input wire logic tick,
   input wire post_cfg_s cfg,
   output logic clk_out
);
   // ==========================================
   // period, high time and start point
   logic [8:0] period;
   logic [8:0] high;
   logic [9:0] start_raw;
   logic [8:0] start;
   logic [8:0] phase_eff;
   logic [8:0] cnt_ff;
   logic [8:0] nxt_cnt;
   assign period = {cfg.div, 3'h0};
   assign high = 9'(cfg.duty * cfg.div);
   assign phase_eff = ({1'b0, cfg.phase} < period) ? {1'b0, cfg.phase} : 9'h000;
   assign start_raw = {1'b0, period} - {1'b0, phase_eff} + {2'h0, COMP};
   assign start = (start_raw >= {1'b0, period}) ? 9'(start_raw - {1'b0, period})
      : start_raw[8:0];
   assign nxt_cnt = (cnt_ff == period - 9'h001) ? 9'h000 : cnt_ff + 9'h001;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 9'h000;
         clk_out <= 1'b0;
      end else if (hold) begin
         cnt_ff <= start;
         clk_out <= 1'b0;
      end else if (tick) begin
         cnt_ff <= nxt_cnt;
         clk_out <= (nxt_cnt < high);
      end
   end
endmodule : pll_post_div

// [verilog/pll_pfd.sv]
// rising-edge phase-frequency detector
// assumes one-cycle event pulses for both edges
`timescale 1ns/1ps
module pll_pfd (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic ref_evt,
   input wire logic fb_evt,
   output logic up,
   output logic down,
   output logic done
);
   logic nxt_up;
   logic nxt_dn;
   assign nxt_up = up | ref_evt;
   assign nxt_dn = down | fb_evt;
   // ==========================================
   // set on edge, both clear once both seen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up <= 1'b0;
         down <= 1'b0;
         done <= 1'b0;
      end else if (clr) begin
         up <= 1'b0;
         down <= 1'b0;
         done <= 1'b0;
      end else begin
         up <= nxt_up & ~nxt_dn;
         down <= nxt_dn & ~nxt_up;
         done <= nxt_up & nxt_dn;
      end
   end
endmodule : pll_pfd

// [verilog/pll_clock_synth_divider.sv]
// digital model of one clock synthesis loop
// assumes synchronous ref_clk_in slower than pclk/2
// How it works
// - output = in times fb over pre times post
// - all dividers take 1 through 32
// - phase step is oscillator period over 8
// - step reaches 125 ps at fastest oscillator
// - 45 degree steps always, finer by ratio
// - two clocks toward the global network
// - one clock for an off-chip pin
// - detector compares rising edges only
// - up raises, down lowers oscillator rate
// - fb divider sits in the feedback path
// - reference is input over pre-divider
// - oscillator feeds three post dividers
// - a,b to global, e to off-chip
// - lock and clocks go to user logic
// - fixed non-adjustable compensation delays
// - at most two loops per device
// - run low holds clocks, drops lock
// - clear resets dividers, outputs, lock
// - detector off stops corrections only
// - lock high when locked, may toggle
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pll_clock_synth_divider import pll_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_clk_in,
   output logic glob_clk_out_a,
   output logic glob_clk_out_b,
   output logic off_chip_clk_out,
   output logic lock_out
);
   // ==========================================
   // declarations
   logic [2:0] ctrl_ff;
   logic [5:0] pre_n_ff;
   logic [5:0] fb_m_ff;
   post_cfg_s ga_cfg_ff;
   post_cfg_s gb_cfg_ff;
   post_cfg_s e_cfg_ff;
   logic [FW_W-1:0] fw_ff;
   logic [FW_W-1:0] acc_ff;
   logic [FW_W-1:0] eff_word;
   logic [FW_W:0] acc_sum;
   logic tick_ff;
   logic ref_q_ff;
   logic [5:0] pre_cnt_ff;
   logic ref_evt_ff;
   logic [8:0] fb_cnt_ff;
   logic fb_evt_ff;
   logic up_raw;
   logic dn_raw;
   logic pfd_done;
   logic up_corr;
   logic dn_corr;
   lock_state_e state_ff;
   logic [7:0] good_cnt_ff;
   logic [7:0] err_cnt_ff;
   logic run;
   logic clear;
   logic det_en;
   logic hold;
   logic ref_rise;
   logic [31:0] rd_mux;
   logic bad_addr;
   logic is_cfg;
   logic wr_en;

   function automatic logic [5:0] clamp_div(input logic [5:0] v);
      if (v < DIV_MIN) begin
         return DIV_MIN;
      end else if (v > DIV_MAX) begin
         return DIV_MAX;
      end
      return v;
   endfunction : clamp_div

   assign run = ctrl_ff[RUN_BIT];
   assign clear = ctrl_ff[CLEAR_BIT];
   assign det_en = ctrl_ff[DETEN_BIT];
   assign hold = ~run | clear;

   // ==========================================
   // apb slave, registered zero-wait answer
   always_comb begin
      rd_mux = 32'h0000_0000;
      bad_addr = 1'b0;
      is_cfg = 1'b1;
      case (paddr)
         CTRL_OFS: begin
            rd_mux[2:0] = ctrl_ff;
            is_cfg = 1'b0;
         end
         DIV_OFS: begin
            rd_mux[5:0] = pre_n_ff;
            rd_mux[FB_POS+:6] = fb_m_ff;
         end
         POST_OFS: begin
            rd_mux[5:0] = ga_cfg_ff.div;
            rd_mux[B_POS+:6] = gb_cfg_ff.div;
            rd_mux[E_POS+:6] = e_cfg_ff.div;
         end
         PHASE_OFS: begin
            rd_mux[7:0] = ga_cfg_ff.phase;
            rd_mux[B_POS+:8] = gb_cfg_ff.phase;
            rd_mux[E_POS+:8] = e_cfg_ff.phase;
         end
         DUTY_OFS: begin
            rd_mux[2:0] = ga_cfg_ff.duty;
            rd_mux[B_POS+:3] = gb_cfg_ff.duty;
            rd_mux[E_POS+:3] = e_cfg_ff.duty;
         end
         STATUS_OFS: begin
            rd_mux[LOCK_BIT] = lock_out;
            rd_mux[UP_BIT] = up_raw;
            rd_mux[DN_BIT] = dn_raw;
            is_cfg = 1'b0;
         end
         FREQ_OFS: begin
            rd_mux[FW_W-1:0] = fw_ff;
         end
         default: begin
            bad_addr = 1'b1;
            is_cfg = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr <= bad_addr | (pwrite & is_cfg & run);
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   assign wr_en = psel & penable & pready & pwrite & ~pslverr;

   // ==========================================
   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_en && paddr == CTRL_OFS) begin
         ctrl_ff <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_n_ff <= DIV_MIN;
         fb_m_ff <= DIV_MIN;
         ga_cfg_ff <= '{DIV_MIN, PHASE_RST, DUTY_RST};
         gb_cfg_ff <= '{DIV_MIN, PHASE_RST, DUTY_RST};
         e_cfg_ff <= '{DIV_MIN, PHASE_RST, DUTY_RST};
      end else if (wr_en) begin
         case (paddr)
            DIV_OFS: begin
               pre_n_ff <= clamp_div(pwdata[5:0]);
               fb_m_ff <= clamp_div(pwdata[FB_POS+:6]);
            end
            POST_OFS: begin
               ga_cfg_ff.div <= clamp_div(pwdata[5:0]);
               gb_cfg_ff.div <= clamp_div(pwdata[B_POS+:6]);
               e_cfg_ff.div <= clamp_div(pwdata[E_POS+:6]);
            end
            PHASE_OFS: begin
               ga_cfg_ff.phase <= pwdata[7:0];
               gb_cfg_ff.phase <= pwdata[B_POS+:8];
               e_cfg_ff.phase <= pwdata[E_POS+:8];
            end
            DUTY_OFS: begin
               ga_cfg_ff.duty <= pwdata[2:0];
               gb_cfg_ff.duty <= pwdata[B_POS+:3];
               e_cfg_ff.duty <= pwdata[E_POS+:3];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // reference pre-divider
   assign ref_rise = ref_clk_in & ~ref_q_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q_ff <= 1'b0;
         pre_cnt_ff <= 6'h00;
         ref_evt_ff <= 1'b0;
      end else begin
         ref_q_ff <= ref_clk_in;
         ref_evt_ff <= 1'b0;
         if (hold) begin
            pre_cnt_ff <= 6'h00;
         end else if (ref_rise) begin
            if (pre_cnt_ff == pre_n_ff - 6'h01) begin
               pre_cnt_ff <= 6'h00;
               ref_evt_ff <= 1'b1;
            end else begin
               pre_cnt_ff <= pre_cnt_ff + 6'h01;
            end
         end
      end
   end

   // ==========================================
   // oscillator: eight ticks per period
   always_comb begin
      eff_word = fw_ff;
      if (up_corr) begin
         eff_word = fw_ff + KP;
      end else if (dn_corr) begin
         eff_word = fw_ff - KP;
      end
   end
   assign acc_sum = {1'b0, acc_ff} + {1'b0, eff_word};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff <= '0;
         tick_ff <= 1'b0;
      end else if (hold) begin
         acc_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         acc_ff <= acc_sum[FW_W-1:0];
         tick_ff <= acc_sum[FW_W];
      end
   end

   // ==========================================
   // feedback divider over 8*m ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_cnt_ff <= 9'h000;
         fb_evt_ff <= 1'b0;
      end else begin
         fb_evt_ff <= 1'b0;
         if (hold) begin
            fb_cnt_ff <= 9'h000;
         end else if (tick_ff) begin
            if (fb_cnt_ff == {fb_m_ff, 3'h0} - 9'h001) begin
               fb_cnt_ff <= 9'h000;
               fb_evt_ff <= 1'b1;
            end else begin
               fb_cnt_ff <= fb_cnt_ff + 9'h001;
            end
         end
      end
   end

   // ==========================================
   // detector and frequency integrator
   pll_pfd u_pfd (
      .pclk(pclk),
      .presetn(presetn),
      .clr(hold),
      .ref_evt(ref_evt_ff),
      .fb_evt(fb_evt_ff),
      .up(up_raw),
      .down(dn_raw),
      .done(pfd_done)
   );

   assign up_corr = up_raw & det_en & ~hold;
   assign dn_corr = dn_raw & det_en & ~hold;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fw_ff <= FW_RST;
      end else if (wr_en && paddr == FREQ_OFS) begin
         fw_ff <= pwdata[FW_W-1:0];
      end else if (up_corr && fw_ff < FW_MAX) begin
         fw_ff <= fw_ff + KI;
      end else if (dn_corr && fw_ff > FW_MIN) begin
         fw_ff <= fw_ff - KI;
      end
   end

   // ==========================================
   // lock detector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         good_cnt_ff <= 8'h00;
         err_cnt_ff <= 8'h00;
         lock_out <= 1'b0;
      end else if (hold) begin
         state_ff <= ST_IDLE;
         good_cnt_ff <= 8'h00;
         err_cnt_ff <= 8'h00;
         lock_out <= 1'b0;
      end else begin
         if (pfd_done) begin
            err_cnt_ff <= 8'h00;
         end else if ((up_raw | dn_raw) && err_cnt_ff != 8'hFF) begin
            err_cnt_ff <= err_cnt_ff + 8'h01;
         end
         case (state_ff)
            ST_IDLE: begin
               state_ff <= ST_ACQ;
            end
            ST_ACQ: begin
               if (pfd_done && err_cnt_ff <= LOCK_WIN) begin
                  good_cnt_ff <= good_cnt_ff + 8'h01;
                  if (good_cnt_ff == LOCK_CNT - 8'h01) begin
                     state_ff <= ST_LOCK;
                  end
               end else if (pfd_done) begin
                  good_cnt_ff <= 8'h00;
               end
            end
            ST_LOCK: begin
               if (pfd_done && err_cnt_ff > LOCK_WIN) begin
                  state_ff <= ST_ACQ;
                  good_cnt_ff <= 8'h00;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
         lock_out <= (state_ff == ST_LOCK);
      end
   end

   // ==========================================
   // post-scale dividers, one loop instance of MAX_LOOPS
   pll_post_div #(.COMP(GLOB_COMP)) glob_post_div_a (
      .pclk(pclk),
      .presetn(presetn),
      .hold(hold),
      .tick(tick_ff),
      .cfg(ga_cfg_ff),
      .clk_out(glob_clk_out_a)
   );

   pll_post_div #(.COMP(GLOB_COMP)) glob_post_div_b (
      .pclk(pclk),
      .presetn(presetn),
      .hold(hold),
      .tick(tick_ff),
      .cfg(gb_cfg_ff),
      .clk_out(glob_clk_out_b)
   );

   pll_post_div #(.COMP(OFF_COMP)) off_chip_post_div (
      .pclk(pclk),
      .presetn(presetn),
      .hold(hold),
      .tick(tick_ff),
      .cfg(e_cfg_ff),
      .clk_out(off_chip_clk_out)
   );

   // ==========================================
   // assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_hold_low;
      hold |=> !glob_clk_out_a && !glob_clk_out_b && !off_chip_clk_out;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("clock out while held");

   property p_clear_lock;
      clear |=> !lock_out;
   endproperty
   a_clear_lock: assert property (p_clear_lock) else $error("lock during clear");

   property p_run_lock;
      !run ##1 !run |-> !lock_out;
   endproperty
   a_run_lock: assert property (p_run_lock) else $error("lock while stopped");

   property p_up_rise;
      up_corr && fw_ff < FW_MAX && !wr_en |=> fw_ff == $past(fw_ff) + KI;
   endproperty
   a_up_rise: assert property (p_up_rise) else $error("up did not raise rate");

   property p_dn_fall;
      dn_corr && fw_ff > FW_MIN && !wr_en |=> fw_ff == $past(fw_ff) - KI;
   endproperty
   a_dn_fall: assert property (p_dn_fall) else $error("down did not lower rate");

   property p_no_corr;
      !det_en && !wr_en |=> $stable(fw_ff);
   endproperty
   a_no_corr: assert property (p_no_corr) else $error("correction with detector off");

   property p_div_range;
      pre_n_ff >= DIV_MIN && pre_n_ff <= DIV_MAX && fb_m_ff >= DIV_MIN && fb_m_ff <= DIV_MAX;
   endproperty
   a_div_range: assert property (p_div_range) else $error("divider out of range");

   property p_static_cfg;
      run && $past(run) |-> $stable(pre_n_ff) && $stable(fb_m_ff) && $stable(ga_cfg_ff);
   endproperty
   a_static_cfg: assert property (p_static_cfg) else $error("config changed while running");

   property p_pre_div;
      ref_evt_ff |-> $past(pre_cnt_ff) == pre_n_ff - 6'h01 && $past(ref_rise);
   endproperty
   a_pre_div: assert property (p_pre_div) else $error("pre-divider miscount");

   property p_lock_src;
      lock_out |-> $past(state_ff) == ST_LOCK;
   endproperty
   a_lock_src: assert property (p_lock_src) else $error("lock without lock state");

   c_locked: cover property (!lock_out ##1 lock_out);
   c_drift: cover property (lock_out && !det_en);
   c_phase: cover property (run && gb_cfg_ff.phase != PHASE_RST && $rose(glob_clk_out_b));
endmodule : pll_clock_synth_divider

// [sim/ref_clk_src.sv]
// reference clock source standing in for the board oscillator
// assumes pclk and presetn from the bench; low and still while run_en is low
`timescale 1ns/1ps
module ref_clk_src #(
   parameter int HALF = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run_en,
   output logic ref_clk
);
   // ==========================================
   // half-period counter
   int cnt_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 0;
         ref_clk <= 1'h0;
      end else if (!run_en) begin
         cnt_ff <= 0;
         ref_clk <= 1'h0;
      end else if (cnt_ff == HALF - 1) begin
         cnt_ff <= 0;
         ref_clk <= ~ref_clk;
      end else begin
         cnt_ff <= cnt_ff + 1;
      end
   end
endmodule : ref_clk_src

// [sim/tb_top.sv]
// self-checking bench for the clock synthesis block
// assumes apb access and a slow reference from ref_clk_src
`timescale 1ns/1ps
module tb_top import pll_pkg::*;;
   localparam int REF_P = 64;
   localparam int WIN = 512;
   localparam int TICK = REF_P / (2 * STEPS_PER_OSC);
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic ref_run = 1'h0;
   logic [31:0] prdata;
   logic pready, pslverr, ref_clk_in, glob_clk_out_a, glob_clk_out_b, off_chip_clk_out, lock_out;
   logic [31:0] rd;
   logic err;
   int errors = 0;
   int compares = 0;
   int na, nb, ne, hi_any, hi_b, dly;

   pll_clock_synth_divider u_pll_clock_synth_divider (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ref_clk_in(ref_clk_in), .glob_clk_out_a(glob_clk_out_a),
      .glob_clk_out_b(glob_clk_out_b), .off_chip_clk_out(off_chip_clk_out), .lock_out(lock_out));
   ref_clk_src #(.HALF(REF_P / 2)) u_ref_clk_src (.pclk(pclk), .presetn(presetn), .run_en(ref_run),
      .ref_clk(ref_clk_in));

   initial forever #4 pclk = ~pclk;

   // ==========================================
   // checking and closing
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic chk1(input string what, input logic seen, input logic exp);
      check(what, {31'h0, seen}, {31'h0, exp});
   endtask : chk1

   function automatic logic near(input int s, input int e, input int t);
      return (s >= e - t) && (s <= e + t);
   endfunction : near

   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // ==========================================
   // apb master
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 50) begin
         errors++;
         tally_and_finish();
      end
   endtask : apb

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic ee);
      apb(1'h0, a, 32'h0);
      check($sformatf("rdata at %h", a), rd, e);
      chk1($sformatf("pslverr at %h", a), err, ee);
   endtask : rchk

   // ==========================================
   // output observation
   task automatic wait_lock();
      int n;
      n = 0;
      while (lock_out !== 1'h1 && n < 40000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40000) begin
         errors++;
         tally_and_finish();
      end
   endtask : wait_lock

   task automatic measure(input int cyc);
      int last_a;
      logic pa, pb, pe;
      na = 0;
      nb = 0;
      ne = 0;
      hi_any = 0;
      hi_b = 0;
      dly = -1;
      last_a = -1000;
      pa = glob_clk_out_a;
      pb = glob_clk_out_b;
      pe = off_chip_clk_out;
      for (int i = 0; i < cyc; i++) begin
         @(posedge pclk);
         if (glob_clk_out_a === 1'h1 && pa === 1'h0) begin
            na++;
            last_a = i;
         end
         if (glob_clk_out_b === 1'h1 && pb === 1'h0) begin
            nb++;
            dly = i - last_a;
         end
         if (off_chip_clk_out === 1'h1 && pe === 1'h0) ne++;
         if (glob_clk_out_b === 1'h1) hi_b++;
         if ((glob_clk_out_a | glob_clk_out_b | off_chip_clk_out | lock_out) !== 1'h0) hi_any++;
         pa = glob_clk_out_a;
         pb = glob_clk_out_b;
         pe = off_chip_clk_out;
      end
   endtask : measure

   // ==========================================
   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      rchk(CTRL_OFS, 32'h00000004, 1'h0);
      rchk(DIV_OFS, 32'h00000101, 1'h0);
      rchk(POST_OFS, 32'h00010101, 1'h0);
      rchk(PHASE_OFS, 32'h00000000, 1'h0);
      rchk(DUTY_OFS, 32'h00040404, 1'h0);
      rchk(STATUS_OFS, 32'h00000000, 1'h0);
      rchk(FREQ_OFS, {8'h00, FW_RST}, 1'h0);
      rchk(8'h1C, 32'h00000000, 1'h1);
      apb(1'h1, DIV_OFS, 32'h00003F00);
      rchk(DIV_OFS, 32'h00002001, 1'h0);
      apb(1'h1, POST_OFS, 32'h00212000);
      rchk(POST_OFS, 32'h00202001, 1'h0);
      // m 2, n 1, posts 1/2/4, b shifted 4 steps, b duty 2
      apb(1'h1, DIV_OFS, 32'h00000201);
      apb(1'h1, POST_OFS, 32'h00040201);
      apb(1'h1, FREQ_OFS, 32'h00400000);
      apb(1'h1, PHASE_OFS, 32'h00000400);
      apb(1'h1, DUTY_OFS, 32'h00040204);
      ref_run <= 1'h1;
      apb(1'h1, CTRL_OFS, 32'h00000005);
      wait_lock();
      apb(1'h0, STATUS_OFS, 32'h0);
      chk1("status lock", rd[LOCK_BIT], 1'h1);
      apb(1'h1, DIV_OFS, 32'h00000303);
      chk1("busy write err", err, 1'h1);
      rchk(DIV_OFS, 32'h00000201, 1'h0);
      repeat (256) @(posedge pclk);
      measure(WIN);
      chk1("rate a", near(na, WIN * 2 / REF_P, 1), 1'h1);
      chk1("rate b", near(nb, WIN * 2 / (REF_P * 2), 1), 1'h1);
      chk1("rate e", near(ne, WIN * 2 / (REF_P * 4), 1), 1'h1);
      chk1("phase b", near(dly, 4 * TICK, 2), 1'h1);
      chk1("duty b", near(hi_b, nb * 4 * TICK, 2 * nb), 1'h1);
      // detector off, reference gone: outputs keep running
      ref_run <= 1'h0;
      apb(1'h1, CTRL_OFS, 32'h00000001);
      measure(WIN);
      chk1("free run a", near(na, WIN * 2 / REF_P, 2), 1'h1);
      apb(1'h1, CTRL_OFS, 32'h00000000);
      repeat (2) @(posedge pclk);
      measure(256);
      check("stopped outputs", hi_any, 0);
      apb(1'h1, FREQ_OFS, 32'h00400000);
      rchk(FREQ_OFS, 32'h00400000, 1'h0);
      apb(1'h1, CTRL_OFS, 32'h00000007);
      repeat (2) @(posedge pclk);
      measure(256);
      check("cleared outputs", hi_any, 0);
      ref_run <= 1'h1;
      apb(1'h1, CTRL_OFS, 32'h00000005);
      wait_lock();
      chk1("relock", lock_out, 1'h1);
      tally_and_finish();
   end
endmodule : tb_top
